/* design/ccc_pkg.sv */
// Package of constants for the constant-current chopper
package ccc_pkg;
	// Off period lengths in internal clock rising edges
	localparam logic [2:0] CCC_OFF_LONG     = 3'h5;
	localparam logic [2:0] CCC_OFF_SHORT    = 3'h3;
	// Value of the off-count select after reset (0 = five edges)
	localparam logic       CCC_OFFSEL_RST   = 1'h0;
	// Dead time in system clock cycles
	localparam logic [3:0] CCC_DEAD_CYC     = 4'h2;
	// Default divider from reference clock edges to internal clock
	localparam int         CCC_DIV_DEFAULT  = 4;
	// Register offsets
	localparam logic [3:0] CCC_REG_CTRL     = 4'h0;
	localparam logic [3:0] CCC_REG_SPEED    = 4'h4;
	localparam logic [3:0] CCC_REG_STATUS   = 4'h8;
	// Control register field positions
	localparam int         CCC_F_OFFSEL     = 0;
	localparam int         CCC_F_METHOD     = 1;
	localparam int         CCC_F_LOOPDIS    = 2;
	localparam int         CCC_F_ENABLE     = 3;
	// Control register value after reset: five edges, external PWM, loop on
	localparam logic [3:0] CCC_CTRL_RST     = 4'h0;
	localparam logic [3:0] CCC_SPEED_RST    = 4'h0;
	// Speed reference: 250 Hz base, 100 Hz per step, 16 steps
	localparam int         CCC_SPEED_BASE_HZ = 250;
	localparam int         CCC_SPEED_STEP_HZ = 100;
	// Chopper phases
	typedef enum logic [1:0] {CCC_IDLE, CCC_ON, CCC_DEAD, CCC_BRAKE} ccc_phase_t;
endpackage

/* design/ccc_chopper.sv */
// PWM constant-current chopper with fixed off time and register port
// Contract
// - Alternate drive-on and short brake repeatedly
// - Dead time around every drive-on phase
// - Off period counts divided internal clock edges
// - Three or five edges, five after reset
// - Count starts when high side switches off (code starts it on entering brake, after the dead time)
// - Five-edge count clears on sixth edge
// - Comparator trip ends drive-on phase
// - Drive resumes after counted off period
// - Select speed loop or direct PWM drive
// - Speed reference sixteen steps, 250-1750 Hz
// - Off select: 0 five, 1 three
// - Method select: 0 external, 1 speed loop
// - Loop bit: 0 limit on, 1 off
`timescale 1ns/10ps
module ccc_chopper #(
	parameter int DIV = ccc_pkg::CCC_DIV_DEFAULT  // Ref clock edges per internal clock
) (
	input  wire logic       clk_sys_in,          // System clock, 25 MHz
	input  wire logic       reset_in,            // Synchronous reset, active high
	input  wire logic [3:0] addr_in,             // Register byte address
	input  wire logic [7:0] wdata_in,            // Register write data
	input  wire logic       wr_in,               // Write strobe
	input  wire logic       rd_in,               // Read strobe
	output logic      [7:0] rdata_out,           // Read data, cycle after strobe
	input  wire logic       ref_clk_in,          // External reference clock level
	input  wire logic       sense_voltage_in,    // Comparator: sense at limit
	input  wire logic       ext_pwm_in,          // External PWM drive input
	input  wire logic       speed_drive_in,      // Drive demand from speed loop
	output logic            high_on_out,         // High-side transistors on
	output logic            low_on_out,          // Low-side transistors on
	output logic            brake_out,           // Short brake active
	output logic      [3:0] speed_target_out,    // Target speed step
	output logic            speed_loop_out       // Speed loop selected
);
	import ccc_pkg::*;

	logic [3:0] ctrl_r, ctrl_nxt;
	logic [3:0] speed_r, speed_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic       ref_d_r, ref_d_nxt;
	logic [7:0] div_r, div_nxt;
	logic       tick_r, tick_nxt;
	ccc_phase_t phase_r, phase_nxt;
	logic [3:0] dead_r, dead_nxt;
	logic [2:0] off_r, off_nxt;
	logic       after_on_r, after_on_nxt;
	logic       demand;
	logic [2:0] off_len;

	localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

	// Register port next values
	always_comb begin
		ctrl_nxt  = ctrl_r;
		speed_nxt = speed_r;
		rdata_nxt = 8'h00;
		if (wr_in && addr_in == CCC_REG_CTRL) begin
			ctrl_nxt = wdata_in[3:0];
		end
		if (wr_in && addr_in == CCC_REG_SPEED) begin
			speed_nxt = wdata_in[3:0];
		end
		if (rd_in) begin
			unique case (addr_in)
				CCC_REG_CTRL:   rdata_nxt = {4'h0, ctrl_r};
				CCC_REG_SPEED:  rdata_nxt = {4'h0, speed_r};
				CCC_REG_STATUS: rdata_nxt = {3'h0, off_r, phase_r};
				default:        rdata_nxt = 8'h00;
			endcase
		end
	end

	// Register port state
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ctrl_r  <= CCC_CTRL_RST;
			speed_r <= CCC_SPEED_RST;
			rdata_r <= 8'h00;
		end else begin
			ctrl_r  <= ctrl_nxt;
			speed_r <= speed_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out        = rdata_r;
	assign speed_target_out = speed_r;
	assign speed_loop_out   = ctrl_r[CCC_F_METHOD];

	// Drive demand from selected method, off length from select bit
	always_comb begin
		demand  = ctrl_r[CCC_F_ENABLE] &&
			(ctrl_r[CCC_F_METHOD] ? speed_drive_in : ext_pwm_in);
		off_len = ctrl_r[CCC_F_OFFSEL] ? CCC_OFF_SHORT : CCC_OFF_LONG;
	end

	// Internal clock: one-cycle tick every DIV reference clock rising edges
	always_comb begin
		ref_d_nxt = ref_clk_in;
		div_nxt   = div_r;
		tick_nxt  = 1'b0;
		if (ref_clk_in && !ref_d_r) begin
			if (div_r == DIV_LAST) begin
				div_nxt  = 8'h00;
				tick_nxt = 1'b1;
			end else begin
				div_nxt = div_r + 8'h01;
			end
		end
	end

	// Divider state
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ref_d_r <= 1'b0;
			div_r   <= 8'h00;
			tick_r  <= 1'b0;
		end else begin
			ref_d_r <= ref_d_nxt;
			div_r   <= div_nxt;
			tick_r  <= tick_nxt;
		end
	end

	// Chopper phase machine
	always_comb begin
		phase_nxt    = phase_r;
		dead_nxt     = 4'h0;
		off_nxt      = 3'h0;
		after_on_nxt = after_on_r;
		unique case (phase_r)
			CCC_IDLE: begin
				if (demand) begin
					phase_nxt    = CCC_DEAD;
					after_on_nxt = 1'b0;
				end
			end
			CCC_ON: begin
				if (!demand || (sense_voltage_in && !ctrl_r[CCC_F_LOOPDIS])) begin
					phase_nxt    = CCC_DEAD;
					after_on_nxt = 1'b1;
				end
			end
			CCC_DEAD: begin
				dead_nxt = dead_r + 4'h1;
				if (dead_r == CCC_DEAD_CYC - 4'h1) begin
					dead_nxt = 4'h0;
					if (!demand) begin
						phase_nxt = CCC_IDLE;
					end else if (after_on_r) begin
						phase_nxt = CCC_BRAKE;
					end else begin
						phase_nxt = CCC_ON;
					end
				end
			end
			CCC_BRAKE: begin
				off_nxt = off_r;
				if (tick_r) begin
					if (off_r == off_len) begin
						off_nxt      = 3'h0;
						phase_nxt    = CCC_DEAD;
						after_on_nxt = 1'b0;
					end else begin
						off_nxt = off_r + 3'h1;
					end
				end
				if (!demand) begin
					phase_nxt = CCC_IDLE;
					off_nxt   = 3'h0;
				end
			end
		endcase
	end

	// Phase state
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			phase_r    <= CCC_IDLE;
			dead_r     <= 4'h0;
			off_r      <= 3'h0;
			after_on_r <= 1'b0;
		end else begin
			phase_r    <= phase_nxt;
			dead_r     <= dead_nxt;
			off_r      <= off_nxt;
			after_on_r <= after_on_nxt;
		end
	end

	// Bridge outputs: both off in idle and dead time
	assign high_on_out = (phase_r == CCC_ON);
	assign low_on_out  = (phase_r == CCC_ON) || (phase_r == CCC_BRAKE);
	assign brake_out   = (phase_r == CCC_BRAKE);

	// Dead time always separates on and brake
	a_dead_between: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r == CCC_ON && phase_nxt != CCC_ON |=> phase_r != CCC_BRAKE)
		else $error("brake entered without dead time");

	// Trip ends drive-on
	a_trip_ends_on: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r == CCC_ON && sense_voltage_in && !ctrl_r[CCC_F_LOOPDIS]
		|=> phase_r == CCC_DEAD ##[1:2] phase_r inside {CCC_BRAKE, CCC_IDLE})
		else $error("comparator trip did not end drive");

	// Counter clear outside brake
	a_off_cleared: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r != CCC_BRAKE |-> off_r == 3'h0)
		else $error("off counter not cleared");

	// Counter never passes the selected length
	a_off_bound: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		off_r <= off_len)
		else $error("off counter beyond length");

	// Off period ends on the edge after the count is full
	a_off_end: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r == CCC_BRAKE && tick_r && off_r == off_len && demand
		|=> phase_r == CCC_DEAD && off_r == 3'h0)
		else $error("off period did not end");

	// Counting advances by one per internal edge
	a_off_count: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r == CCC_BRAKE && tick_r && off_r != off_len && demand
		|=> off_r == $past(off_r) + 3'h1)
		else $error("off count did not advance");

	// Brake holds without a tick despite comparator trips
	a_trip_ignored: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r == CCC_BRAKE && !tick_r && demand |=> phase_r == CCC_BRAKE)
		else $error("off period cut short");

	// Drive returns after off period
	a_drive_resumes: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		phase_r == CCC_BRAKE ##1 phase_r == CCC_DEAD && demand
		|-> ##[1:2] phase_r == CCC_ON)
		else $error("drive did not resume");

	// Never high side and brake at once
	a_no_shoot: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!(high_on_out && brake_out))
		else $error("high side on during brake");
endmodule

/* sim/ccc_coil_model.sv */
// Motor coil with sense resistor and comparator facing the bridge
`timescale 1ns/10ps
module ccc_coil_model #(
	parameter int LIMIT = 8  // Current steps at which the sense trips
) (
	input  wire logic clk_sys_in,  // System clock
	input  wire logic reset_in,    // Synchronous reset
	input  wire logic high_on_in,  // High side on
	input  wire logic brake_in,    // Short brake active
	output logic      sense_out    // Comparator: sense at limit
);
	logic [4:0] cur_r;
	// Current ramps one step per cycle under drive, holds in dead time and decays one step per cycle in brake, so the trip outlasts the turn-off
	always_ff @(posedge clk_sys_in) begin
		if (reset_in)
			cur_r <= 5'h0;
		else if (high_on_in && cur_r != 5'h1F)
			cur_r <= cur_r + 5'h1;
		else if (brake_in && cur_r != 5'h0)
			cur_r <= cur_r - 5'h1;
	end
	// Comparator output
	assign sense_out = (cur_r >= LIMIT);
endmodule

/* sim/ccc_chopper_tb.sv */
// Self-checking testbench of the constant-current chopper
`timescale 1ns/10ps
module ccc_chopper_tb;
	import ccc_pkg::*;
	logic       clk = 0, rst = 1, wr = 0, rd = 0, refc = 0, pwm = 0, spd = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wd = 8'h00, rdat;
	logic       sense, hi, lo, brk, loop_sel;
	logic [3:0] tgt;
	int         n_mismatch = 0, n_tests = 0, n5, n3, d, e;
	ccc_chopper #(.DIV(1)) i_ccc_chopper (.clk_sys_in(clk), .reset_in(rst), .addr_in(addr),
		.wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .ref_clk_in(refc),
		.sense_voltage_in(sense), .ext_pwm_in(pwm), .speed_drive_in(spd), .high_on_out(hi),
		.low_on_out(lo), .brake_out(brk), .speed_target_out(tgt), .speed_loop_out(loop_sel));
	ccc_coil_model i_ccc_coil_model (.clk_sys_in(clk), .reset_in(rst), .high_on_in(hi),
		.brake_in(brk), .sense_out(sense));
	// Clock and a reference clock rising every second cycle
	always #20 clk = ~clk;
	always @(posedge clk) refc <= ~refc;
	// Compare and count
	task chk(string nm, logic [7:0] ex, logic [7:0] got);
		n_tests++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Register write, one strobe cycle
	task wreg(logic [3:0] a, logic [7:0] v);
		@(posedge clk);
		wr <= 1; addr <= a; wd <= v;
		@(posedge clk);
		wr <= 0;
	endtask
	// Register read, data taken in the cycle after the strobe
	task rchk(string nm, logic [3:0] a, logic [7:0] ex);
		@(posedge clk);
		rd <= 1; addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(nm, ex, rdat);
	endtask
	// One chop cycle: dead before brake, brake length, dead before drive
	task chop(output int n, output int dd, output int ee);
		int k;
		n = 0; dd = 0; ee = 0;
		for (k = 0; k < 200 && hi !== 1; k++) @(negedge clk);
		for (k = 0; k < 200 && hi === 1; k++) @(negedge clk);
		while (brk !== 1 && dd < 20) begin
			if ({hi, lo} !== 2'b00) dd = 99;
			dd++; @(negedge clk);
		end
		while (brk === 1 && n < 200) begin
			n++; @(negedge clk);
		end
		while (hi !== 1 && ee < 20) begin
			ee++; @(negedge clk);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#800000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		rchk("ctrl", CCC_REG_CTRL, 8'h00);
		rchk("speed", CCC_REG_SPEED, 8'h00);
		rchk("unmapped", 4'hC, 8'h00);
		wreg(CCC_REG_SPEED, 8'h0F);
		#1 chk("target", 8'h0F, {4'h0, tgt});
		@(posedge clk);
		pwm <= 1;
		wreg(CCC_REG_CTRL, 8'h08);
		chop(n5, d, e);
		chk("dead in", CCC_DEAD_CYC, d[7:0]);
		chk("dead out", CCC_DEAD_CYC, e[7:0]);
		chk("brake5 lo", 1, (n5 >= 10 && n5 <= 14));
		chop(n5, d, e);
		chk("repeat", 1, (n5 >= 10 && n5 <= 14));
		wreg(CCC_REG_CTRL, 8'h09);
		chop(n3, d, e);
		chop(n3, d, e);
		chk("brake3", 1, (n3 >= 6 && n3 <= 10));
		wreg(CCC_REG_CTRL, 8'h0C);
		repeat (60) @(negedge clk);
		chk("loop off", 8'h06, {5'h0, hi, lo, brk});
		rchk("status", CCC_REG_STATUS, 8'h01);
		@(posedge clk);
		pwm <= 0;
		repeat (4) @(negedge clk);
		chk("idle", 8'h00, {5'h0, hi, lo, brk});
		@(posedge clk);
		spd <= 1;
		wreg(CCC_REG_CTRL, 8'h0A);
		#1 chk("method", 8'h01, {7'h0, loop_sel});
		chop(n5, d, e);
		chk("speed drive", 1, (n5 >= 10 && n5 <= 14));
		give_verdict;
	end
endmodule
